// File: fsrp_consts.svh
// constants of the fail-safe, reset and pin configuration register bank
// assumes a single 20 MHz clock and one internal register access port
//
// Overview of operation
// [RULE1] threshold field bits 7-4, action after threshold plus one entries
// [RULE2] entry count bits 3-0 counts consecutive entries, saturates at 15
// [RULE3] writing zero to the count field clears the count
// [RULE4] soft reset bit 1 restores register defaults, inhibit stays on
// [RULE5] hard reset bit 0 forces a full power-on reset
// [RULE6] register hard reset sets the power-on flag
// [RULE7] pin config bit 6 set disables the inhibit pin
// [RULE8] pin config bit 5 picks inhibit (0) or fallback (1) function
// [RULE9] bit 4 disables fallback output, only when fallback is selected
// [RULE10] bits 3-2 pick fallback release: third, first trigger, none
// [RULE11] writing one to bit 1 turns fallback off, bit self-clears
// [RULE12] wake config bit 1 disables the wake maximum width check
// [RULE13] wake config bit 0 masks bus wake-up pattern detection
// [RULE14] threshold exceeded runs action: inhibit low 1 s, resets, sleep
// [RULE15] counting and action only while the counter enable is one
// [RULE16] reserved bits read zero and ignore writes
`ifndef FSRP_CONSTS_SVH
`define FSRP_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define FSRP_ADDR_CNTR 8'h18
`define FSRP_ADDR_RST 8'h19
`define FSRP_ADDR_CFG1 8'h1a
`define FSRP_ADDR_CFG2 8'h1b

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define FSRP_THR_HI 7
`define FSRP_THR_LO 4
`define FSRP_CNT_HI 3
`define FSRP_CNT_LO 0
`define FSRP_CNT_MAX 4'hf
`define FSRP_CNT_ZERO 4'h0
`define FSRP_BIT_SOFT 1
`define FSRP_BIT_HARD 0
`define FSRP_BIT_INHIBIT_OUTPUT_DISABLE 6
`define FSRP_BIT_PIN_SEL 5
`define FSRP_BIT_FALLBACK_OUTPUT_DISABLE 4
`define FSRP_REL_HI 3
`define FSRP_REL_LO 2
`define FSRP_BIT_LIMP_OFF 1
`define FSRP_BIT_MAXW_DIS 1
`define FSRP_BIT_WUP_DIS 0
`define FSRP_RST_BYTE 8'h00
`define FSRP_OK_TRIG_LAST 2'h2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define FSRP_CLK_HZ 20000000
`define FSRP_INH_LOW_MS 1000
`define FSRP_INH_LOW_CYC (`FSRP_INH_LOW_MS * (`FSRP_CLK_HZ / 1000))

`endif

// File: fsrp_pkg.sv
// types of the fail-safe, reset and pin configuration register bank
// assumes the constants header is compiled alongside
package fsrp_pkg;

  typedef enum logic [2:0] {
    FSRP_ACT_NONE = 3'b000,
    FSRP_ACT_INH_LOW = 3'b001,
    FSRP_ACT_SOFT = 3'b010,
    FSRP_ACT_HARD = 3'b011,
    FSRP_ACT_SLEEP = 3'b100
  } fsrp_action_e;

  typedef enum logic [1:0] {
    FSRP_REL_THIRD = 2'b00,
    FSRP_REL_FIRST = 2'b01,
    FSRP_REL_NONE = 2'b10,
    FSRP_REL_RSVD = 2'b11
  } fsrp_release_e;

  typedef enum logic [0:0] {
    FSRP_LIMP_OFF = 1'b0,
    FSRP_LIMP_ON = 1'b1
  } fsrp_limp_e;

  typedef struct packed {
    logic inhibit_output_disable;
    logic shared_pin_function_select;
    logic fallback_output_disable;
    fsrp_release_e release_select;
  } fsrp_pin_cfg_s;

  typedef struct packed {
    logic wake_pulse_max_check_disable;
    logic bus_wakeup_mask;
  } fsrp_wake_cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsrp_reg_req_s;

endpackage

// File: fsrp_pulse_timer.sv
// one-shot timer: holds active for a fixed number of cycles after start
// assumes start is a one-cycle pulse; clear abandons a running interval
`include "fsrp_consts.svh"

module fsrp_pulse_timer #(
  parameter int unsigned CYCLES = `FSRP_INH_LOW_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // control
  input wire logic start_i,
  input wire logic clear_i,
  // status
  output logic active_o
);

  logic [24:0] left_reg;
  logic [24:0] left_next;

  assign left_next = clear_i ? 25'h0 :
                     start_i ? 25'(CYCLES) :
                     (left_reg != 25'h0) ? left_reg - 25'h1 : 25'h0;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_reg <= 25'h0;
    end else begin
      left_reg <= left_next;
    end
  end

  assign active_o = (left_reg != 25'h0);

endmodule

// File: fsrp_failsafe_reset_pin_config.sv
// fail-safe entry counter, register resets and shared pin configuration
// assumes register accesses arrive already decoded from the serial port
`include "fsrp_consts.svh"

module fsrp_failsafe_reset_pin_config #(
  parameter int unsigned INH_LOW_CYCLES = `FSRP_INH_LOW_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register access port
  input wire fsrp_pkg::fsrp_reg_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  // fail-safe configuration from the fail-safe config register
  input wire logic failsafe_counter_enable_i,
  input wire fsrp_pkg::fsrp_action_e failsafe_threshold_action_i,
  // fail-safe and watchdog events, one-cycle pulses
  input wire logic failsafe_entry_i,
  input wire logic wd_error_i,
  input wire logic wd_trigger_ok_i,
  // shared inhibit / fallback pin
  output logic shared_pin_o,
  // resets and flags
  output logic soft_reset_o,
  output logic hard_reset_o,
  output logic power_on_flag_set_o,
  output logic sleep_lock_o,
  // wake control
  output logic wake_pulse_max_check_en_o,
  output logic bus_wakeup_en_o
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [3:0] threshold_reg;
  logic [3:0] threshold_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  fsrp_pkg::fsrp_pin_cfg_s pin_cfg_reg;
  fsrp_pkg::fsrp_pin_cfg_s pin_cfg_next;
  fsrp_pkg::fsrp_wake_cfg_s wake_cfg_reg;
  fsrp_pkg::fsrp_wake_cfg_s wake_cfg_next;
  fsrp_pkg::fsrp_limp_e limp_reg;
  fsrp_pkg::fsrp_limp_e limp_next;
  logic [1:0] ok_trig_reg;
  logic [1:0] ok_trig_next;
  logic sleep_lock_reg;
  logic soft_reg;
  logic hard_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  wire wr_cntr = reg_req_i.wr && (reg_req_i.addr == `FSRP_ADDR_CNTR);
  wire wr_rst = reg_req_i.wr && (reg_req_i.addr == `FSRP_ADDR_RST);
  wire wr_cfg1 = reg_req_i.wr && (reg_req_i.addr == `FSRP_ADDR_CFG1);
  wire wr_cfg2 = reg_req_i.wr && (reg_req_i.addr == `FSRP_ADDR_CFG2);
  wire sw_soft = wr_rst && reg_req_i.wdata[`FSRP_BIT_SOFT];
  wire sw_hard = wr_rst && reg_req_i.wdata[`FSRP_BIT_HARD];
  wire limp_off_wr = wr_cfg1 && reg_req_i.wdata[`FSRP_BIT_LIMP_OFF];
  wire cnt_clear_wr = wr_cntr &&
    (reg_req_i.wdata[`FSRP_CNT_HI:`FSRP_CNT_LO] == `FSRP_CNT_ZERO);

  // ----------------------------------------------------------------
  // fail-safe entry counting and threshold action
  // ----------------------------------------------------------------
  wire entry_counted = failsafe_entry_i && failsafe_counter_enable_i; // RULE15
  // count before this entry >= threshold: entries now exceed threshold
  wire threshold_hit = entry_counted && (count_reg >= threshold_reg); // RULE1
  wire act_inh_low = threshold_hit &&
    (failsafe_threshold_action_i == fsrp_pkg::FSRP_ACT_INH_LOW); // RULE14
  wire act_soft = threshold_hit &&
    (failsafe_threshold_action_i == fsrp_pkg::FSRP_ACT_SOFT); // RULE14
  wire act_hard = threshold_hit &&
    (failsafe_threshold_action_i == fsrp_pkg::FSRP_ACT_HARD); // RULE14
  wire act_sleep = threshold_hit &&
    (failsafe_threshold_action_i == fsrp_pkg::FSRP_ACT_SLEEP); // RULE14

  // software and action resets both restore register defaults
  wire do_hard = sw_hard || act_hard; // RULE5
  wire do_soft = sw_soft || act_soft || do_hard; // RULE4

  // saturating entry count; a same-cycle clear and new entry leave a count of one
  wire [3:0] count_inc = (count_reg == `FSRP_CNT_MAX) ? `FSRP_CNT_MAX :
                         count_reg + 4'h1; // RULE2
  wire [3:0] count_base = cnt_clear_wr ? `FSRP_CNT_ZERO : count_reg; // RULE3
  assign count_next = do_soft ? `FSRP_CNT_ZERO :
                      entry_counted ? (cnt_clear_wr ? 4'h1 : count_inc) :
                      count_base;

  assign threshold_next = do_soft ? `FSRP_CNT_ZERO :
    wr_cntr ? reg_req_i.wdata[`FSRP_THR_HI:`FSRP_THR_LO] : threshold_reg;

  // ----------------------------------------------------------------
  // pin and wake configuration
  // ----------------------------------------------------------------
  // only the documented bits are stored; reserved bits are dropped
  assign pin_cfg_next = do_soft ? fsrp_pkg::fsrp_pin_cfg_s'(5'h0) :
    wr_cfg1 ? fsrp_pkg::fsrp_pin_cfg_s'({
      reg_req_i.wdata[`FSRP_BIT_INHIBIT_OUTPUT_DISABLE],
      reg_req_i.wdata[`FSRP_BIT_PIN_SEL],
      reg_req_i.wdata[`FSRP_BIT_FALLBACK_OUTPUT_DISABLE],
      reg_req_i.wdata[`FSRP_REL_HI:`FSRP_REL_LO]}) : pin_cfg_reg; // RULE16
  assign wake_cfg_next = do_soft ? fsrp_pkg::fsrp_wake_cfg_s'(2'h0) :
    wr_cfg2 ? fsrp_pkg::fsrp_wake_cfg_s'({
      reg_req_i.wdata[`FSRP_BIT_MAXW_DIS],
      reg_req_i.wdata[`FSRP_BIT_WUP_DIS]}) : wake_cfg_reg; // RULE16

  // ----------------------------------------------------------------
  // fallback output state and release
  // ----------------------------------------------------------------
  wire rel_first = (pin_cfg_reg.release_select == fsrp_pkg::FSRP_REL_FIRST);
  wire rel_third = (pin_cfg_reg.release_select == fsrp_pkg::FSRP_REL_THIRD);
  wire trig_release = wd_trigger_ok_i && (rel_first ||
    (rel_third && ok_trig_reg == `FSRP_OK_TRIG_LAST)); // RULE10

  always_comb begin
    limp_next = limp_reg;
    ok_trig_next = ok_trig_reg;
    case (limp_reg)
      fsrp_pkg::FSRP_LIMP_OFF: begin
        ok_trig_next = 2'h0;
        if (wd_error_i) begin
          limp_next = fsrp_pkg::FSRP_LIMP_ON;
        end
      end
      fsrp_pkg::FSRP_LIMP_ON: begin
        if (wd_error_i) begin
          ok_trig_next = 2'h0;
        end else if (limp_off_wr || trig_release) begin
          limp_next = fsrp_pkg::FSRP_LIMP_OFF; // RULE11
          ok_trig_next = 2'h0;
        end else if (wd_trigger_ok_i) begin
          ok_trig_next = ok_trig_reg + 2'h1; // RULE10
        end
      end
      default: begin
        limp_next = fsrp_pkg::FSRP_LIMP_OFF;
        ok_trig_next = 2'h0;
      end
    endcase
    if (do_soft) begin
      limp_next = fsrp_pkg::FSRP_LIMP_OFF;
      ok_trig_next = 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  always_comb begin
    case (reg_req_i.addr)
      `FSRP_ADDR_CNTR: rdata_next = {threshold_reg, count_reg}; // RULE2
      `FSRP_ADDR_CFG1: rdata_next = {1'b0,
        pin_cfg_reg.inhibit_output_disable,
        pin_cfg_reg.shared_pin_function_select,
        pin_cfg_reg.fallback_output_disable,
        pin_cfg_reg.release_select, 2'b00}; // RULE16
      `FSRP_ADDR_CFG2: rdata_next = {6'h0,
        wake_cfg_reg.wake_pulse_max_check_disable,
        wake_cfg_reg.bus_wakeup_mask}; // RULE16
      default: rdata_next = `FSRP_RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      threshold_reg <= `FSRP_CNT_ZERO;
      count_reg <= `FSRP_CNT_ZERO;
      pin_cfg_reg <= fsrp_pkg::fsrp_pin_cfg_s'(5'h0);
      wake_cfg_reg <= fsrp_pkg::fsrp_wake_cfg_s'(2'h0);
      limp_reg <= fsrp_pkg::FSRP_LIMP_OFF;
      ok_trig_reg <= 2'h0;
    end else begin
      threshold_reg <= threshold_next;
      count_reg <= count_next;
      pin_cfg_reg <= pin_cfg_next;
      wake_cfg_reg <= wake_cfg_next;
      limp_reg <= limp_next;
      ok_trig_reg <= ok_trig_next;
    end
  end

  // sleep lock survives soft reset, ends only with power-on reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_lock_reg <= 1'b0;
      soft_reg <= 1'b0;
      hard_reg <= 1'b0;
      rdata_reg <= `FSRP_RST_BYTE;
    end else begin
      sleep_lock_reg <= (sleep_lock_reg || act_sleep) && !do_hard; // RULE14
      soft_reg <= do_soft; // RULE4
      hard_reg <= do_hard; // RULE5
      rdata_reg <= reg_req_i.rd ? rdata_next : rdata_reg;
    end
  end

  // ----------------------------------------------------------------
  // inhibit low interval
  // ----------------------------------------------------------------
  logic inh_low_active;

  fsrp_pulse_timer #(
    .CYCLES(INH_LOW_CYCLES)
  ) u_inh_low (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .start_i(act_inh_low),
    .clear_i(do_soft),
    .active_o(inh_low_active)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire inh_level = !pin_cfg_reg.inhibit_output_disable &&
                   !inh_low_active; // RULE7
  wire limp_level = (limp_reg == fsrp_pkg::FSRP_LIMP_ON) &&
                    !pin_cfg_reg.fallback_output_disable; // RULE9
  assign shared_pin_o = pin_cfg_reg.shared_pin_function_select ?
                        limp_level : inh_level; // RULE8
  assign soft_reset_o = soft_reg;
  assign hard_reset_o = hard_reg;
  assign power_on_flag_set_o = hard_reg; // RULE6
  assign sleep_lock_o = sleep_lock_reg;
  assign wake_pulse_max_check_en_o =
    !wake_cfg_reg.wake_pulse_max_check_disable; // RULE12
  assign bus_wakeup_en_o = !wake_cfg_reg.bus_wakeup_mask &&
                           !sleep_lock_reg; // RULE13
  assign reg_rdata_o = rdata_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cfg_first;
    wr_cfg1 && !sw_soft && reg_req_i.wdata[`FSRP_REL_HI:`FSRP_REL_LO] == 2'b01
      && !reg_req_i.wdata[`FSRP_BIT_LIMP_OFF];
  endsequence
  sequence s_limp_on_ok;
    limp_reg == fsrp_pkg::FSRP_LIMP_ON && wd_trigger_ok_i && !wd_error_i
      && !reg_req_i.wr;
  endsequence

  count_saturate_a: assert property ( // RULE2
    count_reg == 4'hf && entry_counted && !reg_req_i.wr && !do_soft
      |=> count_reg == 4'hf)
    else $error("entry count did not saturate");
  count_clear_a: assert property ( // RULE3
    cnt_clear_wr && !failsafe_entry_i && !sw_hard |=> count_reg == 4'h0)
    else $error("entry count not cleared by zero write");
  counter_disabled_a: assert property ( // RULE15
    !failsafe_counter_enable_i && !reg_req_i.wr |=> $stable(count_reg))
    else $error("entry counted while counter disabled");
  inh_low_start_a: assert property ( // RULE14
    act_inh_low && !do_soft |=> inh_low_active [*8])
    else $error("inhibit low interval not started");
  soft_defaults_a: assert property ( // RULE4
    sw_soft |=> pin_cfg_reg == 5'h0 && threshold_reg == 4'h0 && soft_reset_o)
    else $error("soft reset did not restore defaults");
  hard_power_flag_a: assert property ( // RULE6
    sw_hard |=> hard_reset_o && power_on_flag_set_o
      ##1 (!hard_reset_o || $past(do_hard)))
    else $error("hard reset pulse or power-on flag wrong");
  inh_disable_pin_a: assert property ( // RULE7
    !pin_cfg_reg.shared_pin_function_select &&
    pin_cfg_reg.inhibit_output_disable |-> !shared_pin_o)
    else $error("inhibit pin driven while disabled");
  limp_release_a: assert property ( // RULE11
    limp_off_wr && !wd_error_i |=> limp_reg == fsrp_pkg::FSRP_LIMP_OFF)
    else $error("fallback not released by release bit");
  first_trig_a: assert property ( // RULE10
    s_cfg_first ##1 s_limp_on_ok |=> limp_reg == fsrp_pkg::FSRP_LIMP_OFF)
    else $error("first trigger did not release fallback");
  bus_wake_mask_a: assert property ( // RULE13
    $past(wr_cfg2 && reg_req_i.wdata[`FSRP_BIT_WUP_DIS] && !do_soft)
      |-> !bus_wakeup_en_o)
    else $error("bus wake-up not masked");
  reserved_zero_a: assert property ( // RULE16
    reg_req_i.rd && reg_req_i.addr == `FSRP_ADDR_CFG1 |=> !reg_rdata_o[7]
      && !reg_rdata_o[1] && !reg_rdata_o[0])
    else $error("reserved bits read nonzero");

endmodule

// File: fsrp_failsafe_reset_pin_config_tb_top.sv
// self-checking bench of the fail-safe, reset and pin configuration bank
// assumes the package and constants header are compiled before this file
module fsrp_failsafe_reset_pin_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned LOW_CYC = 20;

  logic ref_clk_i;
  logic rst_n_i;
  fsrp_pkg::fsrp_reg_req_s req;
  fsrp_pkg::fsrp_action_e act;
  logic [7:0] rdata;
  logic en, entry, wd_err, wd_ok;
  logic pin, soft_rst, hard_rst, pof, sleep_lk, maxw_en, wup_en;
  int errors, checked, soft_cnt, hard_cnt, pof_cnt, exp_soft, exp_hard;
  logic [7:0] v, d, t;
  int n;

  fsrp_failsafe_reset_pin_config #(.INH_LOW_CYCLES(LOW_CYC)) u_dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .reg_req_i(req),
    .reg_rdata_o(rdata),
    .failsafe_counter_enable_i(en),
    .failsafe_threshold_action_i(act),
    .failsafe_entry_i(entry),
    .wd_error_i(wd_err),
    .wd_trigger_ok_i(wd_ok),
    .shared_pin_o(pin),
    .soft_reset_o(soft_rst),
    .hard_reset_o(hard_rst),
    .power_on_flag_set_o(pof),
    .sleep_lock_o(sleep_lk),
    .wake_pulse_max_check_en_o(maxw_en),
    .bus_wakeup_en_o(wup_en)
  );

  // ----------------------------------------------------------------
  // clock and pulse counters
  // ----------------------------------------------------------------
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  always @(negedge ref_clk_i) begin
    if (soft_rst === 1'b1) soft_cnt++;
    if (hard_rst === 1'b1) hard_cnt++;
    if (pof === 1'b1) pof_cnt++;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] sat(input int k);
    return (k > 15) ? 8'h0f : 8'(k);
  endfunction

  // shared pin level with the inhibit timer idle
  function automatic logic exp_pin(input logic [7:0] c, input logic on);
    return c[5] ? (on & ~c[4]) : ~c[6];
  endfunction

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(negedge ref_clk_i);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = dat;
    @(negedge ref_clk_i);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge ref_clk_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge ref_clk_i);
    req.rd = 1'b0;
    q = rdata;
  endtask

  // 0 entry, 1 watchdog error, other correct trigger
  task automatic pulse(input int k);
    @(negedge ref_clk_i);
    case (k)
      0: entry = 1'b1;
      1: wd_err = 1'b1;
      default: wd_ok = 1'b1;
    endcase
    @(negedge ref_clk_i);
    entry = 1'b0;
    wd_err = 1'b0;
    wd_ok = 1'b0;
  endtask

  task automatic wait_cyc(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask

  task automatic chk_pulses();
    wait_cyc(3);
    chk("soft pulses", 8'(exp_soft), 8'(soft_cnt));
    chk("hard pulses", 8'(exp_hard), 8'(hard_cnt));
    chk("power flag pulses", 8'(exp_hard), 8'(pof_cnt));
  endtask

  task automatic end_sim();
    if (errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n_i = 1'b0;
    req = '0;
    act = fsrp_pkg::FSRP_ACT_NONE;
    {en, entry, wd_err, wd_ok} = 4'h0;
    {errors, checked, soft_cnt, hard_cnt, pof_cnt} = '0;
    {exp_soft, exp_hard} = '0;
    void'($urandom(52233));
    wait_cyc(3);
    rst_n_i = 1'b1;
    // defaults, unmapped and reserved places
    for (int a = 8'h18; a <= 8'h1b; a++) begin
      rd(8'(a), v);
      chk("reset value", 8'h00, v);
    end
    chk("pin at reset", 8'h01, {7'h00, pin});
    wr(8'h19, 8'hfc);
    wr(8'h40 + 8'($urandom % 8'h80), 8'hff);
    rd(8'h19, v);
    chk("reset ctrl read", 8'h00, v);
    rd(8'h77, v);
    chk("unmapped read", 8'h00, v);
    chk_pulses();
    // random configuration bytes
    repeat (8) begin
      d = 8'($urandom);
      d[1] = 1'b0;
      wr(8'h1a, d);
      rd(8'h1a, v);
      chk("pin config", d & 8'h7c, v);
      chk("shared pin", {7'h00, exp_pin(d, 1'b0)}, {7'h00, pin});
      d = 8'($urandom);
      wr(8'h1b, d);
      rd(8'h1b, v);
      chk("wake config", d & 8'h03, v);
      chk("max check en", {7'h00, ~d[1]}, {7'h00, maxw_en});
      chk("bus wake en", {7'h00, ~d[0]}, {7'h00, wup_en});
    end
    // entry counting, saturation, clearing, enable
    wr(8'h1a, 8'h00);
    en = 1'b1;
    t = 8'($urandom % 16);
    wr(8'h18, {t[3:0], 4'h5});
    rd(8'h18, v);
    chk("threshold write", {t[3:0], 4'h0}, v);
    for (int i = 1; i <= 17; i++) begin
      pulse(0);
      rd(8'h18, v);
      chk("entry count", {t[3:0], 4'h0} | sat(i), v);
    end
    wr(8'h18, {t[3:0], 4'h9});
    rd(8'h18, v);
    chk("count nonzero write", {t[3:0], 4'hf}, v);
    wr(8'h18, {t[3:0], 4'h0});
    rd(8'h18, v);
    chk("count clear", {t[3:0], 4'h0}, v);
    en = 1'b0;
    pulse(0);
    rd(8'h18, v);
    chk("count disabled", {t[3:0], 4'h0}, v);
    // inhibit low after threshold plus one entries
    en = 1'b1;
    act = fsrp_pkg::FSRP_ACT_INH_LOW;
    wr(8'h18, 8'h20);
    for (int i = 1; i <= 2; i++) begin
      pulse(0);
      chk("pin before action", 8'h01, {7'h00, pin});
    end
    pulse(0);
    n = 0;
    while (pin === 1'b0 && n < 100) begin
      n++;
      @(negedge ref_clk_i);
    end
    if (n >= 100) begin
      $display("CHECK FAILED inhibit low wait expected end seen timeout");
      errors++;
      end_sim();
    end
    chk("inhibit low cycles", 8'(LOW_CYC), 8'(n));
    chk("pin after action", 8'h01, {7'h00, pin});
    // soft reset by action and by register
    act = fsrp_pkg::FSRP_ACT_SOFT;
    wr(8'h1a, 8'h58);
    wr(8'h18, 8'h00);
    pulse(0);
    exp_soft++;
    chk_pulses();
    rd(8'h1a, v);
    chk("config after soft", 8'h00, v);
    en = 1'b0;
    wr(8'h1a, 8'h40);
    chk("inhibit disabled", 8'h00, {7'h00, pin});
    wr(8'h19, 8'h02);
    exp_soft++;
    chk_pulses();
    chk("inhibit on after soft", 8'h01, {7'h00, pin});
    rd(8'h1a, v);
    chk("config after soft reg", 8'h00, v);
    // hard reset by register
    wr(8'h1b, 8'h03);
    wr(8'h19, 8'h01);
    exp_hard++;
    exp_soft++;
    chk_pulses();
    rd(8'h1b, v);
    chk("wake after hard", 8'h00, v);
    rd(8'h19, v);
    chk("reset bits clear", 8'h00, v);
    // sleep lock survives soft reset, hard action clears it
    en = 1'b1;
    act = fsrp_pkg::FSRP_ACT_SLEEP;
    pulse(0);
    chk("sleep lock", 8'h01, {7'h00, sleep_lk});
    chk("wake blocked", 8'h00, {7'h00, wup_en});
    en = 1'b0;
    wr(8'h19, 8'h02);
    exp_soft++;
    chk_pulses();
    chk("sleep after soft", 8'h01, {7'h00, sleep_lk});
    en = 1'b1;
    act = fsrp_pkg::FSRP_ACT_HARD;
    pulse(0);
    exp_hard++;
    exp_soft++;
    chk_pulses();
    chk("sleep after hard", 8'h00, {7'h00, sleep_lk});
    chk("wake after hard", 8'h01, {7'h00, wup_en});
    en = 1'b0;
    act = fsrp_pkg::FSRP_ACT_NONE;
    // fallback release methods
    for (int m = 0; m < 4; m++) begin
      d = 8'h20 | 8'(m << 2);
      wr(8'h1a, d);
      chk("fallback idle", 8'h00, {7'h00, pin});
      pulse(1);
      chk("fallback on", 8'h01, {7'h00, pin});
      for (int k = 1; k <= 3; k++) begin
        pulse(2);
        chk("fallback trigger", {7'h00, (m == 1) ? 1'b0 :
            (m == 0 && k == 3) ? 1'b0 : 1'b1}, {7'h00, pin});
      end
      wr(8'h1a, d | 8'h02);
      chk("fallback release", 8'h00, {7'h00, pin});
      rd(8'h1a, v);
      chk("release bit clear", d, v);
    end
    // release field switched to first trigger just before a trigger
    wr(8'h1a, 8'h28);
    pulse(1);
    @(negedge ref_clk_i);
    req.wr = 1'b1;
    req.addr = 8'h1a;
    req.wdata = 8'h24;
    @(negedge ref_clk_i);
    req.wr = 1'b0;
    wd_ok = 1'b1;
    @(negedge ref_clk_i);
    wd_ok = 1'b0;
    chk("first trigger release", 8'h00, {7'h00, pin});
    wr(8'h1a, 8'h30);
    pulse(1);
    chk("fallback disabled", 8'h00, {7'h00, pin});
    wr(8'h1a, 8'h20);
    chk("fallback enabled", 8'h01, {7'h00, pin});
    wr(8'h1a, 8'h22);
    chk("fallback release", 8'h00, {7'h00, pin});
    end_sim();
  end
endmodule
